/* fxp_operand_unit.sv */
// fixed-point operand unit: register file, address generation, load and condition code
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "fxp_defs.svh"
module fxp_operand_unit (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    import fxp_pkg::*;

    // register file and state
    word_t      gpr_ff [16];
    word_t      instr_ff;
    word_t      memdata_ff;
    word_t      result_ff;
    word_t      addr_ff;
    cc_t        cc_ff;
    logic       ovf_ff;
    logic       spec_ff;
    logic       wen_ff;
    logic       store_ff;
    logic       busy_ff;
    logic       aw_ok_ff;
    logic       w_ok_ff;
    logic [7:0] awaddr_ff;
    word_t      wdata_ff;
    logic [3:0] wstrb_ff;

    // sign/negation helpers
    function automatic word_t negate(input word_t v);
        negate = ~v + 32'h1;
    endfunction : negate

    function automatic cc_t arith_cc(input word_t v, input logic ovf);
        if (ovf) begin
            arith_cc = 2'd3;
        end else if (v == 32'h0) begin
            arith_cc = 2'd0;
        end else if (v[31]) begin
            arith_cc = 2'd1;
        end else begin
            arith_cc = 2'd2;
        end
    endfunction : arith_cc

    function automatic word_t sext16(input logic [15:0] h);
        sext16 = {{16{h[15]}}, h};
    endfunction : sext16

    // instruction field decode
    wire [7:0]  opcode   = instr_ff[31:24];
    wire [3:0]  first_reg_field  = instr_ff[23:20];
    wire [3:0]  second_reg_field = instr_ff[19:16];
    wire [3:0]  index_field      = instr_ff[19:16];
    wire [3:0]  base_field       = instr_ff[15:12];
    wire [11:0] displacement_field = instr_ff[11:0];
    wire        reg_storage_format = (opcode[7:6] == 2'b10);
    wire        is_half  = (opcode == `OP_CPH);
    wire        is_shift = opcode inside {`OP_SLA, `OP_SRA};
    wire        is_mem   = opcode inside {`OP_L, `OP_CPH, `OP_ST, `OP_LM};
    wire [3:0]  idx_sel  = reg_storage_format ? 4'h0 : index_field; // index omitted
    wire opsize_e op_size = is_half ? sz_half : sz_full;

    // operands read before any write-back of this instruction
    wire word_t op1 = gpr_ff[first_reg_field];
    wire word_t op2 = gpr_ff[second_reg_field];
    wire word_t eff_addr;
    wire        misaligned;

    fxp_addr_gen u_addr (
        .index_val          (gpr_ff[idx_sel]),
        .base_val           (gpr_ff[base_field]),
        .index_field        (idx_sel),
        .base_field         (base_field),
        .displacement_field (displacement_field),
        .op_size            (op_size),
        .eff_addr           (eff_addr),
        .misaligned         (misaligned)
    ); // address comes from pre-execution register values

    // storage operand, widened where halfword
    wire word_t mem_op = is_half ? sext16(memdata_ff[15:0]) : memdata_ff;
    wire [5:0]  sh_amt = eff_addr[5:0];
    wire [32:0] add_sum = {1'b0, op1} + {1'b0, op2};
    wire [32:0] sub_sum = {1'b0, op1} + {1'b0, ~op2} + 33'h1;
    wire        add_ovf = (op1[31] == op2[31]) && (add_sum[31] != op1[31]);
    wire        sub_ovf = (op1[31] != op2[31]) && (sub_sum[31] != op1[31]);
    wire        neg_ovf = (op2 == `MAX_NEG);
    wire word_t neg_val = neg_ovf ? op2 : negate(op2);
    wire word_t sra_val = word_t'($signed(op1) >>> sh_amt);
    wire word_t sla_low = word_t'(op1 << sh_amt);
    wire word_t sla_val = {op1[31], sla_low[30:0]}; // sign kept
    wire [63:0] sla_ext = {{32{op1[31]}}, op1} << sh_amt;
    wire        sla_ovf = (sla_ext[63:31] != {33{op1[31]}});
    wire        cmp_lt = $signed(op1) < $signed(op2);

    // execution: result, code, flags
    word_t exe_res;
    cc_t   exe_cc;
    logic  exe_setcc;
    logic  exe_ovf;
    logic  exe_wen;
    logic  exe_store;
    always_comb begin
        exe_res   = op1;
        exe_cc    = cc_ff;
        exe_setcc = 1'b0;
        exe_ovf   = 1'b0;
        exe_wen   = 1'b0;
        exe_store = 1'b0;
        case (opcode)
            `OP_CPR: begin
                exe_res = op2;
                exe_wen = 1'b1;
            end
            `OP_CPT: begin
                exe_res   = op2;
                exe_wen   = 1'b1;
                exe_setcc = 1'b1;
                exe_cc    = arith_cc(op2, 1'b0);
            end
            `OP_LCR: begin
                exe_res   = neg_val;
                exe_ovf   = neg_ovf;
                exe_wen   = 1'b1;
                exe_setcc = 1'b1;
                exe_cc    = arith_cc(neg_val, neg_ovf);
            end
            `OP_LPR: begin
                exe_res   = op2[31] ? neg_val : op2;
                exe_ovf   = neg_ovf;
                exe_wen   = 1'b1;
                exe_setcc = 1'b1;
                exe_cc    = arith_cc(exe_res, neg_ovf);
            end
            `OP_LNR: begin
                exe_res   = op2[31] ? op2 : negate(op2);
                exe_wen   = 1'b1;
                exe_setcc = 1'b1;
                exe_cc    = arith_cc(exe_res, 1'b0);
            end
            `OP_AR: begin
                exe_res   = add_sum[31:0]; // carry into sign alters it
                exe_ovf   = add_ovf;
                exe_wen   = 1'b1;
                exe_setcc = 1'b1;
                exe_cc    = arith_cc(add_sum[31:0], add_ovf);
            end
            `OP_SR: begin
                exe_res   = sub_sum[31:0];
                exe_ovf   = sub_ovf;
                exe_wen   = 1'b1;
                exe_setcc = 1'b1;
                exe_cc    = arith_cc(sub_sum[31:0], sub_ovf);
            end
            `OP_CR: begin
                exe_setcc = 1'b1;
                exe_cc    = (op1 == op2) ? 2'd0 : (cmp_lt ? 2'd1 : 2'd2);
            end
            `OP_ALR: begin
                exe_res   = add_sum[31:0];
                exe_wen   = 1'b1;
                exe_setcc = 1'b1;
                exe_cc    = {add_sum[32], add_sum[31:0] != 32'h0};
            end
            `OP_SLR: begin
                exe_res   = sub_sum[31:0];
                exe_wen   = 1'b1;
                exe_setcc = 1'b1;
                exe_cc    = {sub_sum[32], sub_sum[31:0] != 32'h0};
            end
            `OP_SLA: begin
                exe_res   = sla_val;
                exe_ovf   = sla_ovf;
                exe_wen   = 1'b1;
                exe_setcc = 1'b1;
                exe_cc    = arith_cc(sla_val, sla_ovf);
            end
            `OP_SRA: begin
                exe_res   = sra_val;
                exe_wen   = 1'b1;
                exe_setcc = 1'b1;
                exe_cc    = arith_cc(sra_val, 1'b0);
            end
            `OP_L, `OP_CPH: begin
                exe_res = mem_op; // code untouched
                exe_wen = !misaligned;
            end
            `OP_ST: begin
                exe_res   = op1; // result goes to storage
                exe_store = !misaligned;
            end
            default: begin
                exe_res = op1; // other operations leave code
            end
        endcase
    end

    // bus decode
    wire        wr_fire  = aw_ok_ff && w_ok_ff && !s_axi_bvalid;
    wire        rd_fire  = s_axi_arvalid && s_axi_arready;
    wire        wr_gpr   = awaddr_ff[7:6] == 2'b01;
    wire        wr_known = wr_gpr || (awaddr_ff inside {`OFS_INSTR, `OFS_CTRL, `OFS_MEMDATA});
    wire        go       = wr_fire && (awaddr_ff == `OFS_CTRL) && wstrb_ff[0] && wdata_ff[`CTRL_GO_BIT];
    wire        rd_gpr   = s_axi_araddr[7:6] == 2'b01;
    wire [63:0] status_word = {34'h0, cc_ff, 28'h0};
    wire word_t status_val = {25'h0, store_ff, wen_ff, busy_ff, spec_ff, ovf_ff,
                              status_word[63-`CC_HI_POS], status_word[63-`CC_LO_POS]};
    wire word_t rd_val = rd_gpr ? gpr_ff[s_axi_araddr[5:2]] :
                         (s_axi_araddr == `OFS_INSTR)   ? instr_ff :
                         (s_axi_araddr == `OFS_STATUS)  ? status_val :
                         (s_axi_araddr == `OFS_RESULT)  ? result_ff :
                         (s_axi_araddr == `OFS_ADDR)    ? addr_ff :
                         (s_axi_araddr == `OFS_MEMDATA) ? memdata_ff : 32'h0;
    wire        rd_known = rd_gpr || (s_axi_araddr inside {`OFS_INSTR, `OFS_CTRL, `OFS_STATUS, `OFS_RESULT,
                                                          `OFS_ADDR, `OFS_MEMDATA});
    wire word_t wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

    function automatic word_t merge(input word_t old, input word_t nw, input word_t m);
        merge = (old & ~m) | (nw & m);
    endfunction : merge

    // write address and data capture, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ok_ff  <= 1'b0;
            w_ok_ff   <= 1'b0;
            awaddr_ff <= 8'h0;
            wdata_ff  <= 32'h0;
            wstrb_ff  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok_ff  <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_ok_ff <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok_ff  <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_ok_ff <= 1'b0;
            end
        end
    end

    // bus handshake outputs; ready held off while a word waits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `RESP_OKAY;
            s_axi_rdata   <= 32'h0;
        end else begin
            s_axi_awready <= !aw_ok_ff && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready  <= !w_ok_ff && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // execution commit; software writes lose to a same-cycle commit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_ff   <= 32'h0;
            memdata_ff <= 32'h0;
            result_ff  <= 32'h0;
            addr_ff    <= 32'h0;
            cc_ff      <= 2'd0;
            ovf_ff     <= 1'b0;
            spec_ff    <= 1'b0;
            wen_ff     <= 1'b0;
            store_ff   <= 1'b0;
            busy_ff    <= 1'b0;
            for (int i = 0; i < 16; i++) begin
                gpr_ff[i] <= 32'h0;
            end
        end else begin
            busy_ff <= go;
            if (busy_ff) begin
                result_ff <= exe_res;
                addr_ff   <= is_shift ? {26'h0, sh_amt} : eff_addr;
                ovf_ff    <= exe_ovf;
                spec_ff   <= is_mem && misaligned;
                wen_ff    <= exe_wen;
                store_ff  <= exe_store;
                if (exe_setcc) begin
                    cc_ff <= exe_cc;
                end
                if (exe_wen) begin
                    gpr_ff[first_reg_field] <= exe_res;
                end
            end else if (wr_fire && wr_gpr) begin
                gpr_ff[awaddr_ff[5:2]] <= merge(gpr_ff[awaddr_ff[5:2]], wdata_ff, wmask);
            end else if (wr_fire && (awaddr_ff == `OFS_INSTR)) begin
                instr_ff <= merge(instr_ff, wdata_ff, wmask);
            end else if (wr_fire && (awaddr_ff == `OFS_MEMDATA)) begin
                memdata_ff <= merge(memdata_ff, wdata_ff, wmask);
            end
        end
    end
endmodule : fxp_operand_unit

/* fxp_defs.svh */
// constants for the fixed-point operand unit
`ifndef FXP_DEFS_SVH
`define FXP_DEFS_SVH
`define OFS_INSTR      8'h00
`define OFS_CTRL       8'h04
`define OFS_STATUS     8'h08
`define OFS_RESULT     8'h0c
`define OFS_ADDR       8'h10
`define OFS_MEMDATA    8'h14
`define OFS_GPR_BASE   8'h40
`define CTRL_GO_BIT    0
`define CC_HI_POS      34
`define CC_LO_POS      35
`define ST_CC_LSB      0
`define ST_OVF_BIT     2
`define ST_SPEC_BIT    3
`define ST_BUSY_BIT    4
`define ST_WEN_BIT     5
`define ST_STORE_BIT   6
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10
`define MAX_NEG        32'h8000_0000
`define OP_CPR         8'h18
`define OP_CPT         8'h12
`define OP_LCR         8'h13
`define OP_LPR         8'h10
`define OP_LNR         8'h11
`define OP_AR          8'h1a
`define OP_SR          8'h1b
`define OP_CR          8'h19
`define OP_ALR         8'h1e
`define OP_SLR         8'h1f
`define OP_L           8'h58
`define OP_CPH         8'h48
`define OP_ST          8'h50
`define OP_LM          8'h98
`define OP_SLA         8'h8b
`define OP_SRA         8'h8a
`endif

/* fxp_pkg.sv */
// types for the fixed-point operand unit
package fxp_pkg;
    typedef enum logic [1:0] {fmt_reg, fmt_idx, fmt_sto, fmt_bad} fmt_e;
    typedef enum logic [1:0] {sz_half, sz_full, sz_dbl} opsize_e;
    typedef logic [31:0] word_t;
    typedef logic [1:0]  cc_t;
endpackage : fxp_pkg

/* fxp_addr_gen.sv */
// operand address generation and alignment check
`timescale 1ns/1ps
`include "fxp_defs.svh"
module fxp_addr_gen (
    input  wire logic [31:0]     index_val,
    input  wire logic [31:0]     base_val,
    input  wire logic [3:0]      index_field,
    input  wire logic [3:0]      base_field,
    input  wire logic [11:0]     displacement_field,
    input  wire fxp_pkg::opsize_e op_size,
    output logic [31:0]          eff_addr,
    output logic                 misaligned
);
    import fxp_pkg::*;
    wire [31:0] idx_term = (index_field == 4'h0) ? 32'h0 : index_val;
    wire [31:0] base_term = (base_field == 4'h0) ? 32'h0 : base_val;
    // sum of components; register zero never contributes
    assign eff_addr = idx_term + base_term + {20'h0, displacement_field};
    // natural boundary per operand size
    assign misaligned = (op_size == sz_dbl)  ? (eff_addr[2:0] != 3'h0) :
                        (op_size == sz_full) ? (eff_addr[1:0] != 2'h0) :
                                               eff_addr[0];
endmodule : fxp_addr_gen

/* fxp_operand_unit_properties.sv */
// assertions on the operand unit's bus ports
`timescale 1ns/1ps
`include "fxp_defs.svh"
module fxp_operand_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    logic [7:0]  aw_ff, ar_ff, op_ff;
    logic [31:0] wd_ff;
    logic [1:0]  cc_ff;
    wire         st_rd = s_axi_rvalid && s_axi_rready && (ar_ff == `OFS_STATUS);
    wire  [1:0]  cc    = s_axi_rdata[1:0];
    // last opcode written and last code read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {aw_ff, ar_ff, op_ff, wd_ff, cc_ff} <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) aw_ff <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) wd_ff <= s_axi_wdata;
            if (s_axi_arvalid && s_axi_arready) ar_ff <= s_axi_araddr;
            if (s_axi_bvalid && s_axi_bready && aw_ff == `OFS_INSTR) op_ff <= wd_ff[31:24];
            if (st_rd) cc_ff <= cc;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence status_back;
        st_rd;
    endsequence
    sequence status_after(logic [7:0] code);
        st_rd && op_ff == code;
    endsequence
    AST_OVF_CODE3: assert property (status_back |-> !s_axi_rdata[`ST_OVF_BIT] || cc == 2'h3)
        else $error("overflow flagged without code three");
    AST_SPEC_NO_WRITE: assert property (status_back |-> !(s_axi_rdata[`ST_SPEC_BIT] && s_axi_rdata[`ST_WEN_BIT]))
        else $error("register written despite specification exception");
    AST_STORE_NO_WRITE: assert property (status_back |-> !(s_axi_rdata[`ST_STORE_BIT] && s_axi_rdata[`ST_WEN_BIT]))
        else $error("store also wrote a register");
    AST_NEG_CODES: assert property (status_after(`OP_LNR) |-> cc[1] == 1'b0)
        else $error("negative load gave code two or three");
    AST_POS_CODES: assert property (status_after(`OP_LPR) |-> cc != 2'h1)
        else $error("positive load gave code one");
    AST_TEST_CODES: assert property (status_after(`OP_CPT) |-> cc != 2'h3)
        else $error("load and test gave code three");
    AST_CMP_CODES: assert property (status_after(`OP_CR) |-> cc != 2'h3)
        else $error("compare gave code three");
    AST_SHR_CODES: assert property (status_after(`OP_SRA) |-> cc != 2'h3)
        else $error("right shift gave code three");
    AST_KEEP_CODE: assert property (st_rd && op_ff inside {`OP_CPR, `OP_L, `OP_CPH, `OP_LM, `OP_ST} |-> cc == cc_ff)
        else $error("code changed by an operation that must keep it");
    AST_READ_ANSWERS: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read data late");
    AST_READ_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
endmodule : fxp_operand_checker

bind fxp_operand_unit fxp_operand_checker u_fxp_operand_checker (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

/* fxp_seq_model.sv */
// bus master model of the sequencer that loads and runs the unit
`timescale 1ns/1ps
module fxp_seq_model (
    input  wire logic        aclk,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    // idle bus from time zero
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    end
    // one write; released payloads flip to expose late sampling
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr  <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata  <= ~d;
            end
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    // one read; rready stays up until the data is seen
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr  <= ~a;
            end
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
endmodule : fxp_seq_model

/* fxp_operand_unit_tb_top.sv */
// self-checking testbench for the fixed-point operand unit
`timescale 1ns/1ps
`include "fxp_defs.svh"
module fxp_operand_unit_tb_top;
    import fxp_pkg::*;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rsp;
    word_t       st, rv;
    int          miscompares, compares;

    fxp_operand_unit u_fxp_operand_unit (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );
    fxp_seq_model u_fxp_seq_model (
        .aclk(aclk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic chk(input word_t got, input word_t exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude
    task automatic wreg(input logic [7:0] a, input word_t d);
        u_fxp_seq_model.wr(a, d, rsp);
    endtask : wreg
    task automatic rchk(input logic [7:0] a, input word_t e);
        u_fxp_seq_model.rd(a, rv, rsp);
        chk(rv, e);
    endtask : rchk
    function automatic logic [7:0] gpr(input int n);
        return `OFS_GPR_BASE + 8'(n * 4);
    endfunction : gpr
    // load, start, fetch status
    task automatic run(input word_t ins);
        wreg(`OFS_INSTR, ins);
        wreg(`OFS_CTRL, 32'h1);
        u_fxp_seq_model.rd(`OFS_STATUS, st, rsp);
    endtask : run
    // register-register op on registers 1 and 2; s is {spec, overflow, code}
    task automatic rop(input logic [7:0] op, input word_t a, b, r, input logic [3:0] s);
        wreg(gpr(1), a);
        wreg(gpr(2), b);
        run({op, 4'h1, 4'h2, 16'h0});
        chk({28'h0, st[3:0]}, {28'h0, s});
        rchk(gpr(1), r);
        rchk(gpr(2), b);
    endtask : rop

    initial begin
        aresetn = 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(`OFS_STATUS, 32'h0);
        rchk(gpr(5), 32'h0);
        u_fxp_seq_model.rd(8'h30, rv, rsp);
        chk({30'h0, rsp}, {30'h0, `RESP_SLVERR});
        u_fxp_seq_model.wr(8'h3c, 32'h1, rsp);
        chk({30'h0, rsp}, {30'h0, `RESP_SLVERR});
        $display("test reset_decode done");
        // register-register codes, one line per case
        rop(`OP_CPT, 32'h9, 32'h0, 32'h0, 4'h0);
        rop(`OP_CPT, 32'h9, `MAX_NEG, `MAX_NEG, 4'h1);
        rop(`OP_CPT, 32'h9, 32'h1, 32'h1, 4'h2);
        rop(`OP_CPR, 32'h9, 32'hfffffff0, 32'hfffffff0, 4'h2);
        rop(`OP_LCR, 32'h9, 32'h5, 32'hfffffffb, 4'h1);
        rop(`OP_LCR, 32'h9, 32'hffffffff, 32'h1, 4'h2);
        rop(`OP_LCR, 32'h9, `MAX_NEG, `MAX_NEG, 4'h7);
        rop(`OP_LPR, 32'h9, 32'hfffffff9, 32'h7, 4'h2);
        rop(`OP_LPR, 32'h9, `MAX_NEG, `MAX_NEG, 4'h7);
        rop(`OP_LNR, 32'h9, 32'h7, 32'hfffffff9, 4'h1);
        rop(`OP_LNR, 32'h9, 32'h0, 32'h0, 4'h0);
        rop(`OP_AR, 32'h7fffffff, 32'h1, `MAX_NEG, 4'h7);
        rop(`OP_SR, `MAX_NEG, `MAX_NEG, 32'h0, 4'h0);
        rop(`OP_SR, 32'h3, 32'h5, 32'hfffffffe, 4'h1);
        rop(`OP_CR, 32'h3, 32'h5, 32'h3, 4'h1);
        rop(`OP_CR, 32'h5, 32'h3, 32'h5, 4'h2);
        rop(`OP_CR, 32'h5, 32'h5, 32'h5, 4'h0);
        rop(`OP_ALR, 32'hffffffff, 32'h1, 32'h0, 4'h2);
        rop(`OP_ALR, 32'hffffffff, 32'h2, 32'h1, 4'h3);
        rop(`OP_SLR, 32'h5, 32'h3, 32'h2, 4'h3);
        wreg(gpr(3), 32'hfffffff0);
        run({`OP_CPT, 4'h3, 4'h3, 16'h0});
        chk({30'h0, st[1:0]}, 32'h1);
        $display("test register_ops done");
        // storage operands
        wreg(gpr(0), 32'h55);
        wreg(gpr(6), 32'h100);
        wreg(gpr(7), 32'h20);
        wreg(`OFS_MEMDATA, 32'hdeadbeef);
        run({`OP_L, 4'h1, 4'h7, 4'h6, 12'h004});
        rchk(`OFS_ADDR, 32'h124);
        rchk(gpr(1), 32'hdeadbeef);
        run({`OP_L, 4'h3, 4'h0, 4'h0, 12'h008});
        rchk(`OFS_ADDR, 32'h8);
        wreg(`OFS_MEMDATA, 32'h00008001);
        run({`OP_CPH, 4'h1, 4'h0, 4'h6, 12'h002});
        rchk(gpr(1), 32'hffff8001);
        wreg(`OFS_MEMDATA, 32'h12347fff);
        run({`OP_CPH, 4'h1, 4'h0, 4'h6, 12'h006});
        rchk(gpr(1), 32'h7fff);
        run({`OP_L, 4'h1, 4'h0, 4'h6, 12'h002});
        chk({31'h0, st[3]}, 32'h1);
        run({`OP_CPH, 4'h1, 4'h0, 4'h6, 12'h001});
        chk({31'h0, st[3]}, 32'h1);
        rchk(gpr(1), 32'h7fff);
        $display("test storage_ops done");
        // shifts, store, multiple load
        wreg(gpr(1), 32'h80000010);
        run({`OP_SRA, 4'h1, 4'h9, 4'h0, 12'h004});
        rchk(gpr(1), 32'hf8000001);
        chk({28'h0, st[3:0]}, 32'h1);
        wreg(gpr(1), 32'h40000001);
        run({`OP_SLA, 4'h1, 4'h0, 4'h0, 12'h001});
        rchk(gpr(1), 32'h2);
        chk({28'h0, st[3:0]}, 32'h7);
        run({`OP_ST, 4'h1, 4'h0, 4'h6, 12'h008});
        chk({30'h0, st[6:5]}, 32'h2);
        run({`OP_LM, 4'h1, 4'h2, 4'h6, 12'h010});
        rchk(`OFS_ADDR, 32'h110);
        chk({30'h0, st[1:0]}, 32'h3);
        run({`OP_L, 4'h6, 4'h0, 4'h6, 12'h004});
        rchk(`OFS_ADDR, 32'h104);
        rchk(gpr(6), 32'h12347fff);
        $display("test shift_store done");
        conclude();
    end

    // watchdog against a stuck handshake
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        conclude();
    end
endmodule : fxp_operand_unit_tb_top
